// File: tsled_map.vh
`ifndef TSLED_MAP_VH
`define TSLED_MAP_VH

// ****************************************
// temperature
// ****************************************
`define TSLED_TEMP_W 8
`define TSLED_TRIP_C 8'h4b
`define TSLED_SPOT_W 2
`define TSLED_SPOT_MAINBOARD 2'h0
`define TSLED_READ_INVALID 8'h00

// ****************************************
// led colours
// ****************************************
`define TSLED_COL_W 2
`define TSLED_COL_OFF 2'h0
`define TSLED_COL_RED 2'h1
`define TSLED_COL_GREEN 2'h2
`define TSLED_COL_ORANGE 2'h3

// ****************************************
// timing
// ****************************************
`define TSLED_CLK_HZ 125000000
`define TSLED_SLOW_HZ 1
`define TSLED_FAST_HZ 4
`define TSLED_DIV_W 27

`endif

// File: tsled_thermal_status.v
// Behaviour
// - enter partial shutdown when temperature rises above 75 C trip point.
// - commands from host stay accepted during partial shutdown.
// - image acquisition blocked while in partial shutdown.
// - power-saving enable raised in shutdown, about seventy percent power.
// - shutdown stays latched until srst; temperature falling never clears it.
// - spot selector offers mainboard only; reading returned in Celsius.
// - steady red while not initialised and not in partial shutdown.
// - slow red flash while link not configured and not being checked.
// - fast red flash while in partial shutdown.
// - fast orange flash while checking link configuration.
// - steady green when link configured and not acquiring.
// - fast green flash while acquiring.
`timescale 1ns/1ps
`default_nettype none
`include "tsled_map.vh"

module tsled_thermal_status #(
  parameter [`TSLED_DIV_W-1:0] SLOW_HALF = (`TSLED_CLK_HZ / `TSLED_SLOW_HZ) / 2,
  parameter [`TSLED_DIV_W-1:0] FAST_HALF = (`TSLED_CLK_HZ / `TSLED_FAST_HZ) / 2
) (
  input wire clk_sys,
  input wire srst,
  input wire [`TSLED_TEMP_W-1:0] tempSensor,
  input wire tempValid,
  input wire [`TSLED_SPOT_W-1:0] temp_spot_select,
  input wire initDone,
  input wire linkChecking,
  input wire linkConfigured,
  input wire acqActive,
  input wire cmdValid,
  output wire cmdReady,
  output reg [`TSLED_TEMP_W-1:0] temp_reading_celsius,
  output reg shutdownActive,
  output wire acqEnable,
  output wire powerReduce,
  output reg [`TSLED_COL_W-1:0] ledColour
);

  // ****************************************
  // shutdown latch
  // ****************************************
  reg shutdown_q;
  wire overTemp;
  assign overTemp = tempValid && (tempSensor > `TSLED_TRIP_C);

  always @(posedge clk_sys) begin
    if (srst) begin
      shutdown_q <= 1'b0;
    end else if (overTemp) begin
      shutdown_q <= 1'b1;
    end
  end
  // no clear path besides reset

  always @(posedge clk_sys) begin
    if (srst) begin
      shutdownActive <= 1'b0;
    end else begin
      shutdownActive <= shutdown_q | overTemp;
    end
  end

  assign cmdReady = 1'b1;
  assign acqEnable = ~shutdownActive;
  assign powerReduce = shutdownActive;

  // ****************************************
  // temperature readback
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      temp_reading_celsius <= `TSLED_READ_INVALID;
    end else if (tempValid && temp_spot_select == `TSLED_SPOT_MAINBOARD) begin
      temp_reading_celsius <= tempSensor;
    end
  end

  // ****************************************
  // flash dividers
  // ****************************************
  reg [`TSLED_DIV_W-1:0] slowCnt_q;
  reg [`TSLED_DIV_W-1:0] fastCnt_q;
  reg slowPh_q;
  reg fastPh_q;

  always @(posedge clk_sys) begin
    if (srst) begin
      slowCnt_q <= {`TSLED_DIV_W{1'b0}};
      fastCnt_q <= {`TSLED_DIV_W{1'b0}};
      slowPh_q <= 1'b0;
      fastPh_q <= 1'b0;
    end else begin
      if (slowCnt_q >= SLOW_HALF - 1'b1) begin
        slowCnt_q <= {`TSLED_DIV_W{1'b0}};
        slowPh_q <= ~slowPh_q;
      end else begin
        slowCnt_q <= slowCnt_q + 1'b1;
      end
      if (fastCnt_q >= FAST_HALF - 1'b1) begin
        fastCnt_q <= {`TSLED_DIV_W{1'b0}};
        fastPh_q <= ~fastPh_q;
      end else begin
        fastCnt_q <= fastCnt_q + 1'b1;
      end
    end
  end

  // ****************************************
  // led selection
  // ****************************************
  reg [`TSLED_COL_W-1:0] ledColour_d;
  always @* begin
    if (shutdownActive) begin
      ledColour_d = fastPh_q ? `TSLED_COL_RED : `TSLED_COL_OFF;
    end else if (!initDone) begin
      ledColour_d = `TSLED_COL_RED;
    end else if (linkChecking) begin
      ledColour_d = fastPh_q ? `TSLED_COL_ORANGE : `TSLED_COL_OFF;
    end else if (!linkConfigured) begin
      ledColour_d = slowPh_q ? `TSLED_COL_RED : `TSLED_COL_OFF;
    end else if (acqActive) begin
      ledColour_d = fastPh_q ? `TSLED_COL_GREEN : `TSLED_COL_OFF;
    end else begin
      ledColour_d = `TSLED_COL_GREEN;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      ledColour <= `TSLED_COL_RED;
    end else begin
      ledColour <= ledColour_d;
    end
  end

endmodule
`default_nettype wire

// File: tsled_host.sv
`timescale 1ns/1ps
`default_nettype none
module tsled_host(input wire clk_sys, input wire [1:0] mode, output logic linkChecking,
  output logic linkConfigured, output logic cmdValid);
  initial {linkChecking, linkConfigured, cmdValid} = 3'h0;
  // mode 1 checks the link, mode 2 holds it configured
  always @(negedge clk_sys) begin
    linkChecking <= mode == 2'h1;
    linkConfigured <= mode == 2'h2;
    cmdValid <= ~cmdValid;
  end
endmodule
`default_nettype wire

// File: tsled_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tsled_chk(input wire clk_sys, srst, tempValid, initDone, linkChecking, linkConfigured,
  input wire acqActive, cmdValid, cmdReady, shutdownActive, acqEnable, powerReduce,
  input wire [7:0] tempSensor, temp_reading_celsius, input wire [1:0] temp_spot_select, ledColour);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire hot = tempValid && tempSensor > 8'h4b;
  wire calm = !shutdownActive && initDone && !linkChecking && linkConfigured;
  AST_TRIP: assert property (hot |=> shutdownActive) else $error("no trip");
  AST_COOL: assert property (!shutdownActive && !hot |=> !shutdownActive) else $error("trip");
  AST_CMD: assert property (cmdReady) else $error("cmd refused");
  AST_ACQ: assert property (acqEnable != shutdownActive) else $error("acq");
  AST_PWR: assert property (powerReduce == shutdownActive) else $error("power");
  AST_LATCH: assert property (shutdownActive |=> shutdownActive) else $error("unlatched");
  AST_READ: assert property (tempValid && temp_spot_select == 2'h0 |=>
    temp_reading_celsius == $past(tempSensor)) else $error("reading");
  AST_HOTLED: assert property (shutdownActive ##1 shutdownActive |->
    ledColour inside {2'h0, 2'h1}) else $error("hot led");
  AST_UNINIT: assert property (!shutdownActive && !initDone |=> ledColour == 2'h1) else $error("red");
  AST_GREEN: assert property (calm && !acqActive |=> ledColour == 2'h2) else $error("green");
  cover property (hot);
  cover property (calm && acqActive);
  cover property (linkChecking && initDone);
endmodule
`default_nettype wire

// File: tsled_thermal_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsled_map.vh"
module tsled_thermal_status_bench;
  logic clk_sys = 0, srst = 1, tempValid = 0, initDone = 0, acqActive = 1, cmdValid, cmdReady;
  logic linkChecking, linkConfigured, shutdownActive, acqEnable, powerReduce;
  logic [1:0] mode = 1, temp_spot_select = 1, ledColour;
  logic [7:0] tempSensor = 8'h5a, temp_reading_celsius;
  int fail_count = 0, checks = 0, cyc = 0, t;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 3000) begin
    fail_count++;
    test_done;
  end
  tsled_host host(.clk_sys(clk_sys), .mode(mode), .linkChecking(linkChecking),
    .linkConfigured(linkConfigured), .cmdValid(cmdValid));
  tsled_thermal_status #(.SLOW_HALF(27'h8), .FAST_HALF(27'h2)) DUT(.*);
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // counts colour changes over 32 cycles, lit phases must show colour c
  task flash(input logic [1:0] c);
    logic [1:0] p;
    step(3);
    t = 0;
    p = ledColour;
    repeat (32) begin
      step(1);
      if (ledColour !== p) t++;
      if (ledColour !== `TSLED_COL_OFF) chk(ledColour, c);
      p = ledColour;
    end
  endtask
  task t_led;
    flash(`TSLED_COL_RED);
    chk(t, 0);
    initDone = 1;
    flash(`TSLED_COL_ORANGE);
    chk(t > 9, 1);
    mode = 0;
    flash(`TSLED_COL_RED);
    chk(t > 1 && t < 7, 1);
    mode = 2;
    flash(`TSLED_COL_GREEN);
    chk(t > 9, 1);
    acqActive = 0;
    flash(`TSLED_COL_GREEN);
    chk(t, 0);
    $display("led test done");
  endtask
  task t_temp;
    chk(temp_reading_celsius, 0);
    chk(shutdownActive, 0);
    tempSensor = 8'h30;
    tempValid = 1;
    step(2);
    chk(temp_reading_celsius, 0);
    temp_spot_select = 0;
    tempSensor = 8'h4b;
    step(2);
    chk(shutdownActive, 0);
    chk(temp_reading_celsius, 8'h4b);
    tempSensor = 8'h4c;
    step(1);
    chk(shutdownActive, 1);
    chk(cmdReady, 1);
    chk(acqEnable, 0);
    chk(powerReduce, 1);
    tempSensor = 8'h14;
    initDone = 0;
    flash(`TSLED_COL_RED);
    chk(t > 9, 1);
    chk(shutdownActive, 1);
    srst = 1;
    step(2);
    srst = 0;
    step(1);
    chk(shutdownActive, 0);
    $display("temp test done");
  endtask
  task test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    step(5);
    srst = 0;
    t_led;
    t_temp;
    test_done;
  end
endmodule
bind tsled_thermal_status tsled_chk chk_i(.*);
`default_nettype wire
